/* File: fprc_core.sv */
/*
 Floppy rate selection, data separator relock, write gate and gap
 timing, write precompensation and low-power control in one module.
 Assumes the host strobes, bus and raw read data are asynchronous
 pins; the micro-engine signals run on clk_sys.
*/
// Notes on behaviour
// - Non-preamble lock resets PLL to reference.
// - Undecodable bits reported as CRC error.
// - Conventional drive: gate at preamble start.
// - Perpendicular 1 Mbps: gate 38 bytes early.
// - Head offset 38 bytes fast, 19 mid.
// - Perpendicular 1 Mbps gap 2 is 41.
// - Perpendicular mode works at every rate.
// - Config register low bits pick rate.
// - Rate-select low bits also pick rate.
// - Last rate write from either wins.
// - Rate change rescales engine and separator clocks.
// - Precompensation shifts bits early or late.
// - Reset uses default delay, from track zero.
// - Delay and start track are reprogrammable.
// - Power-down clears request_for_master.
// - Stopped clock halts the micro-engine.
// - Rate registers stay writable in power-down.
// - Low-power bit powers down, clears on wake.
// - Manual request is bit OR mode option.
// - Auto low power after 500 ms idle at 500 Kbps.
// - FIFO or status access wakes, holds request.
// - Software reset also wakes the controller.
module fprc_core #(
   parameter int AUTO_LP_TICKS = fprc_pkg::AUTO_LP_TICKS,
   parameter int STABLE_CYC = fprc_pkg::STABLE_CYC
) (
   input wire logic clk_sys, // 100 MHz clock
   input wire logic rstn, // Async reset
   input wire fprc_pkg::fprc_pins_t pins, // Host bus and read pin
   input wire logic dor_reset, // Reset bit of digital_output_reg
   input wire logic low_power_option, // Mode command pulse
   input wire logic auto_lp_enable, // Automatic low power armed
   input wire logic engine_idle, // Micro-engine is idle
   input wire logic engine_ready, // Engine takes commands
   input wire logic perp_mode, // Perpendicular mode set
   input wire logic [7:0] cur_track, // Track under the head
   input wire logic [7:0] precomp_track, // First precomp track
   input wire logic read_active, // Read transfer running
   input wire logic write_active, // Write or format running
   input wire logic gap2_start, // Pulse: gap 2 begins
   input wire logic wr_bit, // Next bit to record
   input wire logic wr_bit_valid, // Write bit offered
   output logic wr_bit_ready, // Pulse: write bit taken
   output logic [7:0] rd_byte, // Separated byte
   output logic rd_byte_valid, // Byte offered
   input wire logic rd_byte_ready, // Receiver takes byte
   output logic crc_error, // Pulse: read ended bad
   output logic write_gate_n, // Write gate
   output logic write_data_n, // Write data pulse
   output logic request_for_master, // Status bit 7
   output logic [1:0] data_rate, // Active rate code
   output logic engine_tick, // Micro-engine enable
   output logic powered_down, // Clock stopped
   output logic soft_reset // Pulse: software reset
);
   import fprc_pkg::*;

   fprc_pins_t s1, s2, s3; // Pin synchroniser
   fprc_pins_t pin_q, pin_d; // Agreed level, last level
   logic wr_ev, rd_ev; // Bus strobe events
   logic wr_rs, wr_cc; // Register writes
   logic [2:0] precomp_code; // Precomp delay select
   logic dsr_lp, mode_lp; // Manual low-power sources
   logic dor_d; // Last digital_output_reg reset
   logic sr_ev, wake_ev; // Reset and wake events
   fprc_pwr_t pwr_st; // Power state
   logic run; // Clock running
   logic [31:0] idle_cnt, stab_cnt; // Power timers
   logic [9:0] cell_len, cell_cnt; // Cell divider
   logic cell_tick; // Last cycle of a cell

   // Three-stage synchroniser; a field moves when stages 2 and 3 agree
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1 <= '1;
         s2 <= '1;
         s3 <= '1;
         pin_q <= '1;
         pin_d <= '1;
      end else begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
         pin_d <= pin_q;
         if (s2.rd_n == s3.rd_n) pin_q.rd_n <= s3.rd_n;
         if (s2.wr_n == s3.wr_n) pin_q.wr_n <= s3.wr_n;
         if (s2.raw_read_n == s3.raw_read_n) begin
            pin_q.raw_read_n <= s3.raw_read_n;
         end
         // Bus fields only move once settled
         if ({s2.addr, s2.data} == {s3.addr, s3.data}) begin
            pin_q.addr <= s3.addr;
            pin_q.data <= s3.data;
         end
      end
   end

   // Write taken at end of strobe, so data has settled
   assign wr_ev = !pin_d.wr_n && pin_q.wr_n;
   assign rd_ev = pin_d.rd_n && !pin_q.rd_n;
   assign wr_rs = wr_ev && (pin_q.addr == OFS_RATE_SEL);
   assign wr_cc = wr_ev && (pin_q.addr == OFS_CFG_CTL);
   assign sr_ev = (wr_rs && pin_q.data[RS_SOFT_RESET])
                  || (dor_reset && !dor_d);
   // Status read, or any data FIFO access, or reset wakes us
   assign wake_ev = (rd_ev && (pin_q.addr == OFS_MAIN_STATUS))
                    || ((rd_ev || wr_ev)
                        && (pin_q.addr == OFS_DATA_FIFO))
                    || sr_ev;

   // Rate and precompensation registers; never gated by power state
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         data_rate <= RATE_RESET;
         precomp_code <= PRECOMP_RESET;
      end else if (wr_rs) begin
         data_rate <= pin_q.data[RS_RATE_LSB +: 2];
         precomp_code <= pin_q.data[RS_PRECOMP_LSB +: 3];
      end else if (wr_cc) begin
         // Upper bits are software's to keep zero; ignored here
         data_rate <= pin_q.data[RS_RATE_LSB +: 2];
      end
   end

   // Software reset pulse, self-clearing as the bit is not stored
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dor_d <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         dor_d <= dor_reset;
         soft_reset <= sr_ev;
      end
   end

   // Manual low-power sources; a new write wins over wake clearing
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dsr_lp <= 1'b0;
         mode_lp <= 1'b0;
      end else begin
         if (wr_rs) begin
            dsr_lp <= pin_q.data[RS_LOW_POWER];
         end else if (pwr_st == PWR_WAKE) begin
            dsr_lp <= 1'b0;
         end
         if (low_power_option) begin
            mode_lp <= 1'b1;
         end else if (pwr_st == PWR_WAKE) begin
            mode_lp <= 1'b0;
         end
      end
   end

   assign run = (pwr_st == PWR_RUN);

   // Idle timer counts engine ticks, so it stretches at slow rates
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         idle_cnt <= '0;
      end else if (!run || !auto_lp_enable || !engine_idle) begin
         idle_cnt <= '0;
      end else if (engine_tick) begin
         idle_cnt <= idle_cnt + 32'd1;
      end
   end

   // Power state machine
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pwr_st <= PWR_RUN;
         stab_cnt <= '0;
         powered_down <= 1'b0;
      end else begin
         unique case (pwr_st)
            PWR_RUN: begin
               // Either source alone powers down at once
               if (dsr_lp || mode_lp
                   || idle_cnt >= 32'(AUTO_LP_TICKS)) begin
                  pwr_st <= PWR_DOWN;
                  powered_down <= 1'b1;
               end
            end
            PWR_DOWN: begin
               if (wake_ev) begin
                  pwr_st <= PWR_WAKE;
                  stab_cnt <= '0;
               end
            end
            PWR_WAKE: begin
               // Wait for the clock to settle before running
               if (stab_cnt >= 32'(STABLE_CYC - 1)) begin
                  pwr_st <= PWR_RUN;
                  powered_down <= 1'b0;
               end else begin
                  stab_cnt <= stab_cnt + 32'd1;
               end
            end
            default: pwr_st <= PWR_RUN;
         endcase
      end
   end

   // Request flag stays low from power-down until settled again
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         request_for_master <= 1'b0;
      end else begin
         request_for_master <= run && engine_ready
                               && !sr_ev;
      end
   end

   // Cell divider; the rate table sets its length
   assign cell_len = cell_cycles(data_rate);
   assign cell_tick = run && (cell_cnt >= cell_len - 10'd1);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cell_cnt <= '0;
         engine_tick <= 1'b0;
      end else if (!run || wr_rs || wr_cc) begin
         // Halted while stopped; restarts on any rate write
         cell_cnt <= '0;
         engine_tick <= 1'b0;
      end else begin
         engine_tick <= cell_tick;
         cell_cnt <= cell_tick ? 10'd0 : cell_cnt + 10'd1;
      end
   end

   // Data separator
   fprc_sep_t sep_st; // Separator state
   logic [9:0] per, ph, half, quart; // Tracked cell and phase
   logic rd_pulse, cell_end, bit_v; // Read pulse, cell close
   logic seen_dat, dec_err, overrun; // Cell and transfer flags
   logic framed; // Byte alignment found
   logic [7:0] pre_cnt, shreg; // Preamble count, bits
   logic [2:0] bit_cnt; // Bits in byte
   logic [15:0] crc; // Running check value
   logic push; // Byte into buffer
   logic [7:0] push_byte; // Byte to buffer
   logic [7:0] tail_byte; // Second buffer entry
   logic tail_valid; // Second entry held

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY)
                            : {r[14:0], 1'b0};
      end
      crc_step = r;
   endfunction

   assign rd_pulse = pin_d.raw_read_n && !pin_q.raw_read_n;
   assign half = per >> 1;
   assign quart = per >> 2;
   assign cell_end = ph >= per - 10'd1;
   assign bit_v = seen_dat || (rd_pulse && ph >= quart
                               && ph < per - quart);

   // Phase tracking and cell decode; frozen while stopped
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         per <= 10'd200;
         ph <= '0;
         seen_dat <= 1'b0;
         dec_err <= 1'b0;
      end else if (run) begin
         if (sep_st == SEP_HUNT) begin
            per <= cell_len;
         end
         if (sep_st == SEP_HUNT && rd_pulse) begin
            // Hunt takes its first pulse as a clock pulse at phase 0,
            // so a preamble cannot settle on the data window
            ph <= 10'd1;
            seen_dat <= 1'b0;
         end else if (cell_end) begin
            ph <= '0;
            seen_dat <= 1'b0;
         end else if (rd_pulse && ph >= quart && ph < per - quart) begin
            // Data pulse: pull phase halfway to the window centre
            ph <= 10'((11'(ph) + 11'(half)) >> 1);
            if (seen_dat) dec_err <= 1'b1;
            seen_dat <= 1'b1;
            if (sep_st != SEP_HUNT && ph > half
                && per < cell_len + (cell_len >> 3)) begin
               per <= per + 10'd1;
            end else if (sep_st != SEP_HUNT && ph < half
                         && per > cell_len - (cell_len >> 3)) begin
               per <= per - 10'd1;
            end
         end else if (rd_pulse && ph < quart) begin
            ph <= (ph >> 1) + 10'd1; // Late clock pulse
         end else begin
            ph <= ph + 10'd1;
         end
         if (sep_st == SEP_HUNT) dec_err <= 1'b0;
      end
   end

   // Hunt, lock on preamble, read; any stray one relocks
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sep_st <= SEP_HUNT;
         pre_cnt <= '0;
         shreg <= '0;
         bit_cnt <= '0;
         framed <= 1'b0;
         crc <= CRC_INIT;
         push <= 1'b0;
         push_byte <= '0;
         overrun <= 1'b0;
         crc_error <= 1'b0;
      end else begin
         push <= 1'b0;
         crc_error <= 1'b0;
         if (!read_active) begin
            if (sep_st == SEP_READ) begin
               crc_error <= (crc != 16'h0000) || dec_err
                            || overrun;
            end
            sep_st <= SEP_HUNT;
         end else if (run) begin
            unique case (sep_st)
               SEP_HUNT: begin
                  pre_cnt <= '0;
                  framed <= 1'b0;
                  bit_cnt <= '0;
                  overrun <= 1'b0;
                  crc <= CRC_INIT;
                  if (rd_pulse) sep_st <= SEP_LOCK;
               end
               SEP_LOCK: begin
                  if (cell_end && bit_v) begin
                     sep_st <= SEP_HUNT;
                  end else if (cell_end) begin
                     pre_cnt <= pre_cnt + 8'd1;
                     if (pre_cnt >= 8'(PREAMBLE_CELLS - 1)) begin
                        sep_st <= SEP_READ;
                     end
                  end
               end
               SEP_READ: begin
                  // First one after preamble aligns the bytes
                  if (cell_end && (framed || bit_v)) begin
                     framed <= 1'b1;
                     shreg <= {shreg[6:0], bit_v};
                     bit_cnt <= bit_cnt + 3'd1;
                     if (bit_cnt == 3'd7) begin
                        push <= !tail_valid;
                        push_byte <= {shreg[6:0], bit_v};
                        crc <= crc_step(crc, {shreg[6:0], bit_v});
                        if (tail_valid) overrun <= 1'b1;
                     end
                  end
               end
               default: sep_st <= SEP_HUNT;
            endcase
         end
      end
   end

   // Two-entry buffer: head drives the outputs, tail absorbs a stall
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_byte <= '0;
         rd_byte_valid <= 1'b0;
         tail_byte <= '0;
         tail_valid <= 1'b0;
      end else if (!rd_byte_valid || rd_byte_ready) begin
         if (tail_valid) begin
            rd_byte <= tail_byte;
            rd_byte_valid <= 1'b1;
            tail_valid <= push;
            tail_byte <= push_byte;
         end else begin
            rd_byte <= push_byte;
            rd_byte_valid <= push;
         end
      end else if (push) begin
         tail_byte <= push_byte;
         tail_valid <= 1'b1;
      end
   end

   // Write side: gap 2 count, gate, bit pattern and pulses
   logic [7:0] gap_bytes, gap2_len, gate_at; // Gap timing
   logic [2:0] gap_bits; // Cells in byte
   logic gap_run, gap_done; // Counting, preamble reached
   logic [2:0] wpat; // Prev, current, next bit
   logic [4:0] pc; // Precomp shift cycles
   logic [9:0] dpos; // Data pulse position
   logic fire; // Start a pulse
   logic [4:0] wp_cnt; // Pulse width

   // Longer gap only for perpendicular media at the fast rate
   assign gap2_len = (perp_mode && data_rate == RATE_1M)
                     ? GAP2_PERP_1M : GAP2_STD;
   // Perpendicular gate leads by the head offset, so the pre-erase head clears
   assign gate_at = perp_mode ? gap2_len - HEAD_OFS[data_rate]
                              : gap2_len;
   assign gap_done = gap_run && gap_bytes >= gap2_len;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         gap_run <= 1'b0;
         gap_bytes <= '0;
         gap_bits <= '0;
         write_gate_n <= 1'b1;
      end else if (!write_active) begin
         gap_run <= 1'b0;
         write_gate_n <= 1'b1;
      end else begin
         if (gap2_start) begin
            gap_run <= 1'b1;
            gap_bytes <= '0;
            gap_bits <= '0;
         end else if (gap_run && cell_tick) begin
            gap_bits <= gap_bits + 3'd1;
            if (gap_bits == 3'd7 && gap_bytes != 8'hff) begin
               gap_bytes <= gap_bytes + 8'd1;
            end
         end
         if (gap_run && gap_bytes >= gate_at) begin
            write_gate_n <= 1'b0;
         end
      end
   end

   // Bit pattern; zeros fill the gap until the preamble is due
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wpat <= '0;
         wr_bit_ready <= 1'b0;
      end else begin
         wr_bit_ready <= cell_tick && gap_done && wr_bit_valid;
         if (write_gate_n) begin
            wpat <= '0;
         end else if (cell_tick) begin
            wpat <= {wpat[1:0], gap_done && wr_bit_valid && wr_bit};
         end
      end
   end

   // Shift away from the nearer neighbour, only from the start track
   assign pc = (cur_track >= precomp_track)
               ? precomp_cycles(precomp_code, data_rate) : 5'd0;
   always_comb begin
      dpos = half;
      if (wpat[2] && !wpat[0]) dpos = half + 10'(pc);
      if (!wpat[2] && wpat[0]) dpos = half - 10'(pc);
   end
   assign fire = !write_gate_n && run
                 && ((cell_cnt == 10'd0 && !wpat[2] && !wpat[1])
                     || (cell_cnt == dpos && wpat[1]));

   // Fixed-width low pulse on the write data pin
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wp_cnt <= '0;
         write_data_n <= 1'b1;
      end else begin
         if (fire) begin
            wp_cnt <= 5'(WPULSE_CYC - 1);
         end else if (wp_cnt != 5'd0) begin
            wp_cnt <= wp_cnt - 5'd1;
         end
         write_data_n <= !(fire || wp_cnt != 5'd0);
      end
   end

   // Precompensation delay in clocks for a code and rate
   function automatic logic [4:0] precomp_cycles(input logic [2:0] code,
                                                 input logic [1:0] rate);
      int ps;
      if (code == PRECOMP_OFF) ps = 0;
      else if (code != 3'h0) ps = int'(code) * PRECOMP_STEP_PS;
      else if (rate == RATE_1M) ps = PRECOMP_DEF_1M_PS;
      else ps = PRECOMP_DEF_PS;
      precomp_cycles = 5'(ps / CLK_PS);
   endfunction
endmodule

/* File: fprc_drive.sv */
/* Drive read head model: plays one MFM flux stream on the first go edge.
 Assumes 500 Kbps cells of CELL clocks and a pulled-up read line. */
module fprc_drive #(
   parameter int CELL = 200
) (
   input wire logic clk_sys, // System clock
   input wire logic go, // Start playback
   output logic raw_read_n // Flux pulses, low
);
   timeunit 1ns;
   timeprecision 100ps;
   // False lock, preamble, two bytes, tail
   localparam logic [63:0] PAT = {6'h01, 40'h0, 16'hc59a, 2'h0};
   logic prev; // Last bit sent
   task automatic flux(input logic p, input int n);
      raw_read_n = !p;
      repeat (5) @(posedge clk_sys);
      #1 raw_read_n = 1'b1; // Pulled up between pulses
      repeat (n - 5) @(posedge clk_sys);
      #1;
   endtask
   // Clock pulse between zeros, data pulse mid cell
   initial begin
      raw_read_n = 1'b1;
      @(posedge go);
      prev = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         flux(!PAT[i] && !prev, CELL / 2);
         flux(PAT[i], CELL - CELL / 2);
         prev = PAT[i];
      end
   end
endmodule

/* File: fprc_pkg.sv */
/*
 Shared constants, types and helpers for the floppy rate, write
 precompensation, separator and low-power block.
 Assumes one 100 MHz system clock and an 8-bit host bus.
*/
package fprc_pkg;
   // System clock
   localparam int CLK_MHZ = 100;
   localparam int CLK_PS = 10000;
   // Host bus offsets
   localparam logic [2:0] OFS_RATE_SEL = 3'h4;
   localparam logic [2:0] OFS_MAIN_STATUS = 3'h4;
   localparam logic [2:0] OFS_DATA_FIFO = 3'h5;
   localparam logic [2:0] OFS_CFG_CTL = 3'h7;
   // Fields of rate_select_power and config_control_rate
   localparam int RS_RATE_LSB = 0;
   localparam int RS_PRECOMP_LSB = 2;
   localparam int RS_LOW_POWER = 6;
   localparam int RS_SOFT_RESET = 7;
   // Reset values
   localparam logic [1:0] RATE_RESET = 2'h0;
   localparam logic [2:0] PRECOMP_RESET = 3'h0;
   // Rate code to kbps; code 3 is the fast rate
   localparam int RATE_KBPS [4] = '{500, 300, 250, 1000};
   localparam logic [1:0] RATE_1M = 2'h3;
   // Head offset in bytes per rate code, and gap 2 lengths
   localparam logic [7:0] HEAD_OFS [4] = '{8'h13, 8'h0b, 8'h0a, 8'h26};
   localparam logic [7:0] GAP2_STD = 8'h16;
   localparam logic [7:0] GAP2_PERP_1M = 8'h29;
   // Precompensation delays
   localparam int PRECOMP_DEF_PS = 125000;
   localparam int PRECOMP_DEF_1M_PS = 41670;
   localparam int PRECOMP_STEP_PS = 41670;
   localparam logic [2:0] PRECOMP_OFF = 3'h7;
   // Timing
   localparam int PREAMBLE_CELLS = 32;
   localparam int WPULSE_NS = 100;
   localparam int WPULSE_CYC = (WPULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int AUTO_LP_MS = 500;
   localparam int AUTO_LP_KBPS = 500;
   localparam int AUTO_LP_TICKS = AUTO_LP_MS * AUTO_LP_KBPS;
   localparam int STABLE_US = 1000;
   localparam int STABLE_CYC = STABLE_US * CLK_MHZ;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   // Pins arriving from outside the clock domain
   typedef struct packed {
      logic [2:0] addr;
      logic rd_n;
      logic wr_n;
      logic [7:0] data;
      logic raw_read_n;
   } fprc_pins_t;

   typedef enum logic [1:0] {
      PWR_RUN = 2'b00, PWR_DOWN = 2'b01, PWR_WAKE = 2'b10
   } fprc_pwr_t;

   typedef enum logic [1:0] {
      SEP_HUNT = 2'b00, SEP_LOCK = 2'b01, SEP_READ = 2'b10
   } fprc_sep_t;

   // Bit cell length in system clocks for a rate code
   function automatic logic [9:0] cell_cycles(input logic [1:0] code);
      cell_cycles = 10'(CLK_MHZ * 1000 / RATE_KBPS[code]);
   endfunction
endpackage

/* File: fprc_props.sv */
/* Port assertions for fprc_core.
 Assumes one clock, clk_sys, and the active low rstn. */
module fprc_props #(
   parameter int STABLE_CYC = 10
) (
   input wire logic clk_sys, // Clock
   input wire logic rstn, // Reset
   input wire fprc_pkg::fprc_pins_t pins, // Host pins
   input wire logic low_power_option, // Mode option
   input wire logic read_active, // Read running
   input wire logic write_active, // Write running
   input wire logic rd_byte_ready, // Receiver ready
   input wire logic [7:0] rd_byte, // Byte
   input wire logic rd_byte_valid, // Byte offered
   input wire logic crc_error, // Bad read
   input wire logic write_gate_n, // Gate
   input wire logic request_for_master, // Status bit 7
   input wire logic [1:0] data_rate, // Rate
   input wire logic engine_tick, // Cell tick
   input wire logic powered_down, // Clock off
   input wire logic soft_reset // Reset pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WAKE_MAX = STABLE_CYC + 20; // Sync slack
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   pd_rqm_a: assert property (
      $rose(powered_down) |=> !request_for_master) else $error("rqm up");
   pd_halt_a: assert property (
      powered_down && $past(powered_down) |-> !engine_tick)
      else $error("tick while down");
   opt_down_a: assert property (
      low_power_option |-> ##[1:4] powered_down) else $error("no sleep");
   rst_wake_a: assert property (
      powered_down && soft_reset |-> ##[1:WAKE_MAX] !powered_down)
      else $error("no wake");
   wake_rqm_a: assert property (
      $fell(powered_down) |-> !request_for_master) else $error("rqm early");
   rate_src_a: assert property (
      $changed(data_rate) |-> pins.wr_n && pins.addr inside {3'h4, 3'h7})
      else $error("rate moved alone");
   gate_idle_a: assert property (
      !write_active && !$past(write_active) |-> write_gate_n)
      else $error("gate without write");
   crc_end_a: assert property (
      crc_error |-> !read_active ##1 !crc_error) else $error("crc pulse");
   buf_hold_a: assert property (
      rd_byte_valid && !rd_byte_ready |=> rd_byte_valid && $stable(rd_byte))
      else $error("byte lost");
   cover property ($rose(powered_down));
   cover property (crc_error);
   cover property ($fell(write_gate_n));
endmodule
bind fprc_core fprc_props #(.STABLE_CYC(STABLE_CYC)) u_props (.clk_sys,
   .rstn, .pins, .low_power_option, .read_active, .write_active,
   .rd_byte_ready, .rd_byte, .rd_byte_valid, .crc_error, .write_gate_n,
   .request_for_master, .data_rate, .engine_tick, .powered_down,
   .soft_reset);

/* File: fprc_tb.sv */
/* Self-checking bench for fprc_core with the drive model.
 Assumes short power counts: 10 clocks to wake, 20 idle ticks. */
module testbench import fprc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0, rstn = 0, dor_reset = 0, low_power_option = 0;
   logic auto_lp_enable = 0, engine_idle = 0, engine_ready = 1, go = 0;
   logic perp_mode = 0, read_active = 0, write_active = 0, gap2_start = 0;
   logic wr_bit = 0, wr_bit_valid = 1, rd_byte_ready = 0, crc_seen = 0;
   logic rd_n = 1, wr_n = 1, raw_n, wr_bit_ready, rd_byte_valid, crc_error;
   logic write_gate_n, request_for_master, engine_tick, powered_down;
   logic soft_reset, wdat_n, wd_seen = 0;
   logic [7:0] cur_track = 0, precomp_track = 0, bus_data = 0, rd_byte;
   logic [2:0] bus_addr = 0;
   logic [1:0] data_rate;
   fprc_pins_t pins;
   int err_total = 0, n_checks = 0, t;
   assign pins = '{bus_addr, rd_n, wr_n, bus_data, raw_n};
   fprc_core #(.AUTO_LP_TICKS(20), .STABLE_CYC(10)) uut (.clk_sys, .rstn,
      .pins, .dor_reset, .low_power_option, .auto_lp_enable, .engine_idle,
      .engine_ready, .perp_mode, .cur_track, .precomp_track, .read_active,
      .write_active, .gap2_start, .wr_bit, .wr_bit_valid, .wr_bit_ready,
      .rd_byte, .rd_byte_valid, .rd_byte_ready, .crc_error, .write_gate_n,
      .write_data_n(wdat_n), .request_for_master, .data_rate, .engine_tick,
      .powered_down, .soft_reset);
   fprc_drive drv (.clk_sys, .go, .raw_read_n(raw_n));
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (crc_error) crc_seen <= 1'b1;
   always @(posedge clk_sys) if (!wdat_n) wd_seen <= 1'b1;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Strobe held five clocks so the synchroniser cannot miss it
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input rd);
      bus_addr = a;
      bus_data = d;
      if (rd) rd_n = 0; else wr_n = 0;
      cyc(5);
      rd_n = 1;
      wr_n = 1;
      cyc(10);
   endtask
   task automatic wr_rate(input logic [2:0] a, input logic [7:0] d);
      bus(a, d, 1'b0);
      chk(8'(data_rate), 8'(d[1:0]));
   endtask
   // Count cell ticks from gap 2 start to the gate falling
   task automatic gate(input p, input logic [1:0] r, input logic [7:0] e);
      wr_rate(OFS_CFG_CTL, 8'(r));
      perp_mode = p;
      write_active = 1;
      gap2_start = 1;
      cyc(1);
      gap2_start = 0;
      for (t = 0; write_gate_n === 1'b1; t += 32'(engine_tick)) cyc(1);
      chk(8'((t + 4) / 8), e);
      cyc(400);
      write_active = 0;
      cyc(5);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(90000);
      err_total++;
      close_out();
   end
   initial begin
      cyc(8);
      rstn = 1;
      cyc(2);
      wr_rate(OFS_CFG_CTL, 8'h01);
      wr_rate(OFS_RATE_SEL, 8'h03);
      wr_rate(OFS_CFG_CTL, 8'hfe);
      wr_rate(OFS_RATE_SEL, 8'h00);
      read_active = 1;
      go = 1;
      cyc(64 * 200 + 50);
      read_active = 0;
      cyc(5);
      chk(8'(crc_seen), 8'h01);
      // Receiver stalled all along; both words must still be held
      for (int i = 0; i < 2; i++) begin
         chk(rd_byte, i ? 8'h9a : 8'hc5);
         rd_byte_ready = 1;
         cyc(1);
         rd_byte_ready = 0;
         cyc(3);
      end
      chk(8'(rd_byte_valid), 8'h00);
      gate(1'b0, 2'h0, 8'h16);
      gate(1'b1, 2'h3, 8'h03);
      gate(1'b1, 2'h0, 8'h03);
      gate(1'b0, 2'h3, 8'h16);
      bus(OFS_RATE_SEL, 8'h43, 1'b0);
      chk(8'(request_for_master), 8'h00);
      wr_rate(OFS_CFG_CTL, 8'h00);
      bus(OFS_MAIN_STATUS, 8'h00, 1'b1);
      cyc(30);
      chk(8'({powered_down, request_for_master}), 8'h01);
      low_power_option = 1;
      cyc(1);
      low_power_option = 0;
      cyc(5);
      chk(8'(powered_down), 8'h01);
      dor_reset = 1;
      cyc(40);
      dor_reset = 0;
      chk(8'(powered_down), 8'h00);
      auto_lp_enable = 1;
      engine_idle = 1;
      cyc(20 * 200 + 100);
      chk(8'(powered_down), 8'h01);
      auto_lp_enable = 0;
      engine_idle = 0;
      bus(OFS_RATE_SEL, 8'h80, 1'b0);
      cyc(30);
      chk(8'(powered_down), 8'h00);
      chk(8'(wd_seen), 8'h01);
      close_out();
   end
endmodule
